// >>> rtl/ulb_defines.svh
`ifndef ULB_DEFINES_SVH
`define ULB_DEFINES_SVH
`define ULB_PIN_NONE    2'b00
`define ULB_PIN_RTS     2'b01
`define ULB_PIN_RTSCTS  2'b10
`define ULB_PIN_BCLK    2'b11
`define ULB_CAL_CHAR    8'h55
`define ULB_ABD_EDGES   3'h5
`define ULB_ABD_DIV     3'h7
`define ULB_BIT_TICKS   4'hf
`define ULB_FIFO_DEPTH  4
`define ULB_FIFO_AW     2
`define ULB_RTS_ROOM    3'h2
`endif

// >>> rtl/ulb_pkg.sv
`default_nettype none
package ulb_pkg;
    typedef enum logic [1:0] {
        ABD_IDLE  = 2'b00,
        ABD_START = 2'b01,
        ABD_COUNT = 2'b10,
        ABD_BREAK = 2'b11
    } ulb_abd_e;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_HOLD  = 2'b01,
        TX_SHIFT = 2'b10
    } ulb_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } ulb_rx_e;
    typedef struct packed {
        logic [1:0] pin_use_select;
        logic       loopback_enable;
        logic       handshake_mode_select;
        logic       wake_enable;
    } ulb_cfg_s;
endpackage
`default_nettype wire

// >>> rtl/ulb_fifo.sv
`include "ulb_defines.svh"
`default_nettype none
module ulb_fifo #(
    parameter int W = 8,
    parameter int D = 4,
    parameter int AW = 2
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [AW:0]        count
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign count     = cnt_q;
    always_ff @(posedge clk) begin
        if (push) mem[wp_q] <= in_data;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ulb_top.sv
`include "ulb_defines.svh"
`default_nettype none
// Functional notes
// - loopback routes tx to rx internally
// - loopback ignores rx pin, tx drives
// - loopback mode 10 feeds cts from rts
// - autobaud never starts in loopback, and with wake only after a break
// - autobaud enable clears counter, waits start
// - calibration char 55h, low and high
// - counter counts at clock over eight
// - fifth rising edge loads divisor, clears enable
// - autobaud holds receiver idle, sets flag
// - break wake precedes autobaud measurement
// - mode 10 cts high holds transmit start
// - cts sampled only before the start bit
// - remote holds cts one clock minimum
// - rts output in modes 01, 10
// - flow mode rts high when busy
// - flow mode rts low needs room two
// - simplex rts low while transmitter busy
module ulb_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire ulb_pkg::ulb_cfg_s cfg,
    input  wire logic        autobaud_set,
    input  wire logic [15:0] baud_divisor_wr,
    input  wire logic        baud_divisor_we,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    input  wire logic        rx_ready,
    input  wire logic        rx_event_clr,
    input  wire logic        serial_in_pin,
    input  wire logic        send_permit_in,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic             serial_out_pin,
    output logic             receive_ready_out,
    output logic             receive_ready_oe,
    output logic             baud_clock_out_pin,
    output logic             autobaud_enable,
    output logic [15:0]      baud_divisor_reg,
    output logic             transmit_idle_flag,
    output logic             rx_event_flag,
    output logic             overrun_flag
);
    // ==========================================================
    // pin routing
    ulb_pkg::ulb_tx_e  tx_st_q;
    ulb_pkg::ulb_rx_e  rx_st_q;
    ulb_pkg::ulb_abd_e abd_q;
    logic       txo_q;
    logic       rts_q;
    logic [3:0] brg_tick_q;
    logic [15:0] brg_cnt_q;
    logic       tick;
    logic       rxin_q;
    logic       lb_cts;
    wire rx_src = cfg.loopback_enable ? txo_q : serial_in_pin;
    // mode 10 loopback cts from rts
    assign lb_cts = cfg.loopback_enable ? rts_q : send_permit_in;
    wire cts_used = (cfg.pin_use_select == `ULB_PIN_RTSCTS);
    wire cts_ok = !cts_used || !lb_cts;
    wire rts_pin = (cfg.pin_use_select == `ULB_PIN_RTS) || cts_used;
    // ==========================================================
    // bit rate tick, 16 per bit
    assign tick = (brg_cnt_q == baud_divisor_reg);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) brg_cnt_q <= '0;
        else brg_cnt_q <= tick ? 16'h0 : brg_cnt_q + 16'h1;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) brg_tick_q <= '0;
        else if (tick) brg_tick_q <= brg_tick_q + 4'h1;
    end
    wire bit_start = tick && (brg_tick_q == `ULB_BIT_TICKS);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) baud_clock_out_pin <= 1'b0;
        else baud_clock_out_pin <= (cfg.pin_use_select == `ULB_PIN_BCLK) && !brg_tick_q[3];
    end
    // ==========================================================
    // transmitter
    logic [9:0] tx_sh_q;
    logic [3:0] tx_n_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_q <= ulb_pkg::TX_IDLE;
            tx_sh_q <= '1;
            tx_n_q  <= '0;
            txo_q   <= 1'b1;
        end else begin
            case (tx_st_q)
                ulb_pkg::TX_IDLE: begin
                    if (tx_valid) begin
                        tx_sh_q <= {1'b1, tx_data, 1'b0};
                        tx_st_q <= ulb_pkg::TX_HOLD;
                    end
                end
                ulb_pkg::TX_HOLD: begin
                    if (bit_start && cts_ok) begin
                        txo_q   <= tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                        tx_n_q  <= 4'h9;
                        tx_st_q <= ulb_pkg::TX_SHIFT;
                    end
                end
                ulb_pkg::TX_SHIFT: begin
                    if (bit_start) begin
                        if (tx_n_q == 4'h0) begin
                            tx_st_q <= ulb_pkg::TX_IDLE;
                        end else begin
                            txo_q   <= tx_sh_q[0];
                            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                            tx_n_q  <= tx_n_q - 4'h1;
                        end
                    end
                end
                default: tx_st_q <= ulb_pkg::TX_IDLE;
            endcase
        end
    end
    assign tx_ready = (tx_st_q == ulb_pkg::TX_IDLE);
    assign serial_out_pin = txo_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) transmit_idle_flag <= 1'b1;
        else transmit_idle_flag <= (tx_st_q == ulb_pkg::TX_IDLE) && !tx_valid;
    end
    // ==========================================================
    // autobaud
    logic [2:0]  div8_q;
    logic [2:0]  edges_q;
    logic [15:0] abd_cnt_q;
    logic        rx_prev_q;
    logic        brk_seen_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rxin_q <= 1'b1;
        else rxin_q <= rx_src;
    end
    wire rise = rxin_q && !rx_prev_q;
    wire fall = !rxin_q && rx_prev_q;
    wire abd_tick = (div8_q == `ULB_ABD_DIV);
    // no start in loopback, or with wake before a break
    wire abd_go = autobaud_enable && (!cfg.wake_enable || brk_seen_q) && !cfg.loopback_enable;
    wire abd_done = (abd_q == ulb_pkg::ABD_COUNT) && rise && (edges_q == `ULB_ABD_EDGES - 3'h1);
    wire abd_busy = (abd_q != ulb_pkg::ABD_IDLE);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_prev_q <= 1'b1;
            div8_q    <= '0;
        end else begin
            rx_prev_q <= rxin_q;
            div8_q    <= div8_q + 3'h1;
        end
    end
    // wake stays set here, so remember the break until measured
    wire brk_end = (abd_q == ulb_pkg::ABD_BREAK) && rise;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) brk_seen_q <= 1'b0;
        else brk_seen_q <= brk_end || (brk_seen_q && autobaud_enable && !abd_done);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            abd_q     <= ulb_pkg::ABD_IDLE;
            abd_cnt_q <= '0;
            edges_q   <= '0;
        end else begin
            case (abd_q)
                ulb_pkg::ABD_IDLE: begin
                    abd_cnt_q <= '0;
                    edges_q   <= '0;
                    if (autobaud_enable && cfg.wake_enable && !brk_seen_q && fall)
                        abd_q <= ulb_pkg::ABD_BREAK;
                    else if (abd_go && fall)
                        abd_q <= ulb_pkg::ABD_START;
                end
                ulb_pkg::ABD_BREAK: begin
                    if (rise) abd_q <= ulb_pkg::ABD_IDLE;
                end
                ulb_pkg::ABD_START: begin
                    // counting begins at start bit end
                    if (rise) begin
                        abd_q   <= ulb_pkg::ABD_COUNT;
                        edges_q <= 3'h1;
                    end
                end
                ulb_pkg::ABD_COUNT: begin
                    if (abd_tick) abd_cnt_q <= abd_cnt_q + 16'h1;
                    if (rise) edges_q <= edges_q + 3'h1;
                    if (abd_done) abd_q <= ulb_pkg::ABD_IDLE;
                end
                default: abd_q <= ulb_pkg::ABD_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            baud_divisor_reg <= 16'h0;
            autobaud_enable  <= 1'b0;
        end else begin
            if (abd_done) baud_divisor_reg <= abd_cnt_q;
            else if (baud_divisor_we) baud_divisor_reg <= baud_divisor_wr;
            if (abd_done) autobaud_enable <= 1'b0;
            else if (autobaud_set) autobaud_enable <= 1'b1;
        end
    end
    // ==========================================================
    // receiver
    logic [7:0] rx_sh_q;
    logic [3:0] rx_n_q;
    logic [3:0] rx_t_q;
    logic       push;
    logic       fifo_rdy;
    logic [2:0] fcnt;
    logic       f_valid;
    logic [7:0] f_data;
    wire rx_hold = autobaud_enable || abd_busy;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_q <= ulb_pkg::RX_IDLE;
            rx_sh_q <= '0;
            rx_n_q  <= '0;
            rx_t_q  <= '0;
            push    <= 1'b0;
        end else begin
            push <= 1'b0;
            if (rx_hold) rx_st_q <= ulb_pkg::RX_IDLE;
            else case (rx_st_q)
                ulb_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_st_q <= ulb_pkg::RX_START;
                        rx_t_q  <= '0;
                    end
                end
                ulb_pkg::RX_START: begin
                    if (tick) rx_t_q <= rx_t_q + 4'h1;
                    if (tick && rx_t_q == 4'h7) begin
                        rx_t_q  <= '0;
                        rx_n_q  <= '0;
                        rx_st_q <= rxin_q ? ulb_pkg::RX_IDLE : ulb_pkg::RX_DATA;
                    end
                end
                ulb_pkg::RX_DATA: begin
                    if (tick) rx_t_q <= rx_t_q + 4'h1;
                    if (tick && rx_t_q == `ULB_BIT_TICKS) begin
                        rx_sh_q <= {rxin_q, rx_sh_q[7:1]};
                        rx_n_q  <= rx_n_q + 4'h1;
                        if (rx_n_q == 4'h7) rx_st_q <= ulb_pkg::RX_STOP;
                    end
                end
                ulb_pkg::RX_STOP: begin
                    if (tick) rx_t_q <= rx_t_q + 4'h1;
                    if (tick && rx_t_q == `ULB_BIT_TICKS) begin
                        push    <= 1'b1;
                        rx_st_q <= ulb_pkg::RX_IDLE;
                    end
                end
                default: rx_st_q <= ulb_pkg::RX_IDLE;
            endcase
        end
    end
    // limitation: full fifo drops char, sets overrun
    ulb_fifo #(.W(8), .D(`ULB_FIFO_DEPTH), .AW(`ULB_FIFO_AW)) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (rx_sh_q),
        .out_valid (f_valid),
        .out_ready (rx_ready && rx_valid),
        .out_data  (f_data),
        .count     (fcnt)
    );
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx_data  <= '0;
        end else begin
            rx_valid <= f_valid && !(rx_ready && rx_valid);
            rx_data  <= (rx_ready && rx_valid) ? rx_data : f_data;
        end
    end
    // set wins over clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overrun_flag  <= 1'b0;
            rx_event_flag <= 1'b0;
        end else begin
            overrun_flag <= (push && !fifo_rdy) || (overrun_flag && !rx_event_clr);
            rx_event_flag <= abd_done || push || (rx_event_flag && !rx_event_clr);
        end
    end
    // ==========================================================
    // handshake output
    wire room2 = (3'(`ULB_FIFO_DEPTH) - fcnt) >= `ULB_RTS_ROOM;
    wire rx_busy = (rx_st_q != ulb_pkg::RX_IDLE);
    wire rts_d = cfg.handshake_mode_select ? transmit_idle_flag
                                           : (!room2 || rx_busy || overrun_flag);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rts_q            <= 1'b1;
            receive_ready_oe <= 1'b0;
        end else begin
            rts_q            <= rts_d;
            // driven in modes 01 and 10
            receive_ready_oe <= rts_pin;
        end
    end
    assign receive_ready_out = rts_q;
    // ==========================================================
    // checks
    // divisor update
    chk_abd_load: assert property (@(posedge clk) disable iff (!rstn)
        abd_done |=> (baud_divisor_reg == $past(abd_cnt_q)) && !autobaud_enable)
        else $error("divisor not loaded");
    chk_abd_flag: assert property (@(posedge clk) disable iff (!rstn)
        abd_done |=> rx_event_flag) else $error("rx event missing");
    chk_rx_hold: assert property (@(posedge clk) disable iff (!rstn)
        rx_hold |=> !push) else $error("fifo changed in autobaud");
    chk_abd_gate: assert property (@(posedge clk) disable iff (!rstn)
        (abd_q == ulb_pkg::ABD_IDLE && !abd_go) |=> abd_q != ulb_pkg::ABD_START)
        else $error("autobaud started wrongly");
    chk_wake_first: assert property (@(posedge clk) disable iff (!rstn)
        (abd_q == ulb_pkg::ABD_IDLE && cfg.wake_enable && !brk_seen_q)
        |=> abd_q != ulb_pkg::ABD_START)
        else $error("wake not first");
    chk_cts_hold: assert property (@(posedge clk) disable iff (!rstn)
        (tx_st_q == ulb_pkg::TX_HOLD && cts_used && lb_cts) |=> tx_st_q != ulb_pkg::TX_SHIFT)
        else $error("sent while cts high");
    chk_rts_oe: assert property (@(posedge clk) disable iff (!rstn)
        ##1 receive_ready_oe == $past(rts_pin)) else $error("rts enable wrong");
    chk_simplex_rts: assert property (@(posedge clk) disable iff (!rstn)
        cfg.handshake_mode_select |=> rts_q == $past(transmit_idle_flag))
        else $error("simplex rts wrong");
    chk_loop_rx: assert property (@(posedge clk) disable iff (!rstn)
        cfg.loopback_enable |=> rxin_q == $past(txo_q)) else $error("loopback route");
endmodule
`default_nettype wire

// >>> test/ulb_remote_term.sv
`default_nettype none
// ========
// remote terminal on the serial pins
module ulb_remote_term (
    input  wire logic clk,
    input  wire logic serial_out_pin,
    output logic      serial_in_pin,
    output logic      send_permit_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        serial_in_pin  = 1'b1;
        send_permit_in = 1'b1;
    end
    task automatic set_permit(input logic lvl);
        @(negedge clk);
        send_permit_in = lvl;
    endtask
    task automatic set_line(input logic lvl);
        @(negedge clk);
        serial_in_pin = lvl;
    endtask
    // line pulled up, so idle is high
    task automatic send_byte(input logic [7:0] b, input int bc);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            serial_in_pin = fr[i];
            repeat (bc - 1) @(negedge clk);
        end
    endtask
    // mid-bit sampling, bounded wait for a start bit
    task automatic recv_byte(input int bc, output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b  = 8'h00;
        for (int n = 0; n < 4000 && !ok; n++) begin
            @(negedge clk);
            ok = (serial_out_pin === 1'b0);
        end
        if (ok) begin
            repeat (bc / 2) @(negedge clk);
            ok = (serial_out_pin === 1'b0);
            for (int i = 0; i < 8; i++) begin
                repeat (bc) @(negedge clk);
                b[i] = serial_out_pin;
            end
            repeat (bc) @(negedge clk);
            ok = ok && (serial_out_pin === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// >>> test/uart_loopback_autobaud_flowctl_tb.sv
`default_nettype none
module uart_loopback_autobaud_flowctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 16;
    ulb_pkg::ulb_cfg_s cfg;
    logic              clk, rstn, autobaud_set, baud_divisor_we, tx_valid;
    logic              rx_ready, rx_event_clr, serial_in_pin, send_permit_in;
    logic              tx_ready, rx_valid, serial_out_pin, receive_ready_out;
    logic              receive_ready_oe, autobaud_enable, transmit_idle_flag;
    logic              rx_event_flag, overrun_flag, ok;
    logic [15:0]       baud_divisor_wr, baud_divisor_reg;
    logic [7:0]        tx_data, rx_data, got;
    int                err_count, compares;

    ulb_top ulb_top_inst (.clk(clk), .rstn(rstn), .cfg(cfg), .autobaud_set(autobaud_set),
        .baud_divisor_wr(baud_divisor_wr), .baud_divisor_we(baud_divisor_we),
        .tx_valid(tx_valid), .tx_data(tx_data), .rx_ready(rx_ready),
        .rx_event_clr(rx_event_clr), .serial_in_pin(serial_in_pin),
        .send_permit_in(send_permit_in), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .serial_out_pin(serial_out_pin),
        .receive_ready_out(receive_ready_out), .receive_ready_oe(receive_ready_oe),
        .baud_clock_out_pin(), .autobaud_enable(autobaud_enable),
        .baud_divisor_reg(baud_divisor_reg), .transmit_idle_flag(transmit_idle_flag),
        .rx_event_flag(rx_event_flag), .overrun_flag(overrun_flag));
    ulb_remote_term ulb_remote_term_inst (.clk(clk), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin), .send_permit_in(send_permit_in));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ========
    // helpers
    task automatic wrap_up();
        $display("tests done: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask
    task automatic give_up(input string m);
        err_count++;
        $display("unexpected at %0t: timeout %s", $time, m);
        wrap_up();
    endtask
    task automatic set_cfg(input logic [1:0] pu, input logic lb, input logic hm);
        @(negedge clk);
        cfg = '{pin_use_select: pu, loopback_enable: lb, handshake_mode_select: hm,
                wake_enable: 1'b0};
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic send_tx(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk);
        tx_data  = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 4000) give_up("tx_ready");
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task automatic take_rx(input logic [7:0] exp);
        int n;
        n = 0;
        while (rx_valid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 4000) give_up("rx_valid");
        end
        check(rx_data, exp, "rx data");
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask

    // ========
    // scenarios
    task automatic t_plain();
        set_cfg(2'h0, 1'b0, 1'b0);
        fork
            ulb_remote_term_inst.recv_byte(BC, got, ok);
            send_tx(8'ha5);
        join
        check({ok, got}, 9'h1a5, "byte without handshake");
        check(receive_ready_oe, 1'b0, "rts undriven mode 00");
        $display("test plain done");
    endtask
    task automatic t_simplex();
        logic held;
        held = 1'b1;
        set_cfg(2'h2, 1'b0, 1'b1);
        send_tx(8'h3c);
        repeat (4 * BC) begin
            @(negedge clk);
            held &= (serial_out_pin === 1'b1);
        end
        check(held, 1'b1, "start held by permit");
        check({receive_ready_oe, receive_ready_out}, 2'h2, "request low");
        fork
            ulb_remote_term_inst.recv_byte(BC, got, ok);
            ulb_remote_term_inst.set_permit(1'b0);
        join
        check({ok, got}, 9'h13c, "byte after permit");
        repeat (2 * BC) @(negedge clk);
        check({transmit_idle_flag, receive_ready_out}, 2'h3, "request off");
        ulb_remote_term_inst.set_permit(1'b1);
        $display("test simplex done");
    endtask
    task automatic t_loop();
        set_cfg(2'h2, 1'b0, 1'b0);
        set_cfg(2'h2, 1'b1, 1'b0);
        ulb_remote_term_inst.set_line(1'b0);
        fork
            ulb_remote_term_inst.recv_byte(BC, got, ok);
            send_tx(8'h96);
        join
        check({ok, got}, 9'h196, "tx pin in loopback");
        take_rx(8'h96);
        ulb_remote_term_inst.set_line(1'b1);
        set_cfg(2'h0, 1'b0, 1'b0);
        $display("test loopback done");
    endtask
    task automatic t_flow();
        set_cfg(2'h1, 1'b0, 1'b0);
        repeat (2) @(negedge clk);
        check({receive_ready_oe, receive_ready_out}, 2'h2, "ready idle");
        ulb_remote_term_inst.send_byte(8'h11, BC);
        fork
            ulb_remote_term_inst.send_byte(8'h22, BC);
            begin
                repeat (5 * BC) @(negedge clk);
                check(receive_ready_out, 1'b1, "rts while shifting");
            end
        join
        ulb_remote_term_inst.send_byte(8'h33, BC);
        repeat (2 * BC) @(negedge clk);
        check(receive_ready_out, 1'b1, "rts with room one");
        take_rx(8'h11);
        take_rx(8'h22);
        take_rx(8'h33);
        repeat (BC) @(negedge clk);
        check(receive_ready_out, 1'b0, "rts after drain");
        $display("test flow done");
    endtask
    task automatic t_autobaud();
        logic inr;
        set_cfg(2'h0, 1'b0, 1'b0);
        pulse(autobaud_set);
        fork
            ulb_remote_term_inst.send_byte(8'h55, 160);
            begin
                repeat (5 * 160) @(negedge clk);
                check(autobaud_enable, 1'b1, "enable mid measure");
            end
        join
        repeat (8) @(negedge clk);
        inr = baud_divisor_reg >= 16'h009e && baud_divisor_reg <= 16'h00a2;
        check(inr, 1'b1, "measured divisor");
        check(autobaud_enable, 1'b0, "enable self clears");
        check({rx_event_flag, rx_valid}, 2'h2, "flag set, fifo untouched");
        pulse(rx_event_clr);
        @(negedge clk);
        check(rx_event_flag, 1'b0, "flag cleared");
        baud_divisor_wr = 16'h0000;
        pulse(baud_divisor_we);
        @(negedge clk);
        check(baud_divisor_reg, 16'h0000, "divisor write");
        set_cfg(2'h0, 1'b1, 1'b0);
        pulse(autobaud_set);
        ulb_remote_term_inst.send_byte(8'h55, 160);
        repeat (8) @(negedge clk);
        check(autobaud_enable, 1'b1, "enable kept in loopback");
        check(baud_divisor_reg, 16'h0000, "no measure");
        $display("test autobaud done");
    endtask
    task automatic t_wake();
        logic inr;
        @(negedge clk);
        cfg = '{pin_use_select: 2'h0, loopback_enable: 1'b0, handshake_mode_select: 1'b0,
                wake_enable: 1'b1};
        ulb_remote_term_inst.set_line(1'b0);
        repeat (13 * BC) @(negedge clk);
        ulb_remote_term_inst.set_line(1'b1);
        repeat (BC) @(negedge clk);
        ulb_remote_term_inst.send_byte(8'h55, BC);
        repeat (8) @(negedge clk);
        inr = baud_divisor_reg >= 16'h000f && baud_divisor_reg <= 16'h0011;
        check(inr, 1'b1, "divisor after break");
        check(autobaud_enable, 1'b0, "enable clears after break");
        $display("test wake done");
    endtask

    initial begin
        cfg = '0;
        {rstn, autobaud_set, baud_divisor_we, tx_valid, rx_ready, rx_event_clr} = '0;
        baud_divisor_wr = 16'h0000;
        tx_data = 8'h00;
        err_count = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        check({serial_out_pin, receive_ready_out, receive_ready_oe}, 3'h6, "reset pins");
        check(baud_divisor_reg, 16'h0000, "reset divisor");
        check({transmit_idle_flag, rx_event_flag, overrun_flag}, 3'h4, "reset flags");
        t_plain();
        t_simplex();
        t_loop();
        t_flow();
        t_autobaud();
        t_wake();
        wrap_up();
    end
endmodule
`default_nettype wire
